/* pef_defines.vh */
// Purpose: Offsets, bit positions and reset values of the event flag registers.
// Assumes: Byte-wide registers addressed by an 8-bit register index.
// Notes: Definitions only.
`ifndef PEF_DEFINES_VH
`define PEF_DEFINES_VH

// ====================================================================
// Register offsets
`define PEF_ADDR_LINK 8'h0b
`define PEF_ADDR_UART 8'h0c
`define PEF_ADDR_RDY 8'h0d

// ====================================================================
// Bit positions, link and moisture register
`define PEF_B_LNG_XFER 7
`define PEF_B_UVLO 6
`define PEF_B_MOI_DONE 5
`define PEF_B_MOI_DET 4
`define PEF_B_MOI_VALID 3
`define PEF_B_RES_ABR 2
`define PEF_B_RES_OPN 1
`define PEF_B_RES_GND 0

// ====================================================================
// Bit positions, serial mode register
`define PEF_B_URT_TMO 7
`define PEF_B_URT_FAIL 6
`define PEF_B_URT_DONE 5
`define PEF_B_URT_SWC 4
`define PEF_B_DEAD 3
`define PEF_B_SWC_OFF 1
`define PEF_B_CHG_PRQ 0

// ====================================================================
// Bit positions, ready and watchdog register
`define PEF_B_ITF_RDY 7
`define PEF_B_WDT_CLR 2

// ====================================================================
// Implemented-bit masks and reset values
`define PEF_MASK_LINK 8'hff
`define PEF_MASK_UART 8'hfb
`define PEF_MASK_RDY 8'h84
`define PEF_RST_LINK 8'h00
`define PEF_RST_UART 8'h00
`define PEF_RST_RDY 8'h80
`define PEF_STS_W 6
`define PEF_ZERO8 8'h00

`endif

/* pef_sync.v */
// Purpose: Two-flop synchroniser bank for asynchronous status inputs.
// Assumes: Inputs come from outside the clock domain.
// Notes: Only the second stage is visible to other logic.
`timescale 1ns/100ps
module pef_sync #(
  parameter W = 6
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  always @(posedge clk) begin
    if (rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // pef_sync

/* pef_event_flags.v */
// Purpose: Three sticky event flag registers at register offsets 0x0b..0x0d.
// Assumes: Status and event inputs are asynchronous levels; register port is single-cycle.
// Notes: Writing 1 to a flag clears it; a new event in the same cycle wins.
`timescale 1ns/100ps
`include "pef_defines.vh"

// Notes on behaviour
// [RULE_01] Long transfer status change sets flag
// [RULE_02] Undervoltage status change sets flag
// [RULE_03] Moisture measurement done sets flag
// [RULE_04] Link moisture status change sets flag
// [RULE_05] Valid moisture result sets flag
// [RULE_06] Resistive abort, open, ground set flags
// [RULE_07] Serial mode timeout sets flag
// [RULE_08] Serial mode entry failure sets flag
// [RULE_09] Serial mode entry or exit sets flag
// [RULE_10] Serial switch open status change sets flag
// [RULE_11] Dead master found sets flag
// [RULE_12] Switch-off mode status change sets flag
// [RULE_13] Charger prerequisite status change sets flag
// [RULE_14] Ready flag resets set; OTP/ready change sets
// [RULE_15] Host reads watchdog bit within limit
// [RULE_16] Watchdog bit one until read after timeout; a self-clear or a write of one also clears it
// [RULE_17] Flags sticky until software writes one
// [RULE_18] Reserved bits read zero, ignore writes
module pef_event_flags (
  input wire CLK,
  input wire RST,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  output wire [7:0] REG_RDATA,
  input wire LNG_XFER_STS,
  input wire BATTERY_UNDERVOLTAGE_STATUS_N,
  input wire LINK_MOISTURE_STS,
  input wire SERIAL_SWITCH_OPEN_STS,
  input wire SWITCH_OFF_STS,
  input wire CHARGER_PREREQ_STS,
  input wire INTERFACE_READY_STS,
  input wire MOI_DONE_EVT,
  input wire MOI_VALID_EVT,
  input wire RES_ABORT_EVT,
  input wire RES_OPEN_EVT,
  input wire RES_GROUND_EVT,
  input wire URT_TIMEOUT_EVT,
  input wire URT_FAIL_EVT,
  input wire URT_ENTER_EVT,
  input wire URT_EXIT_EVT,
  input wire DEAD_MASTER_EVT,
  input wire OTP_DONE_EVT,
  input wire WDT_TIMEOUT_EVT,
  input wire WDT_SELF_CLEAR,
  output wire WDT_SERVICED
);

  // ====================================================================
  // Input synchronisation
  wire [`PEF_STS_W-1:0] sts_s;
  reg [`PEF_STS_W-1:0] sts_prev_q;
  wire [`PEF_STS_W-1:0] sts_chg;
  wire [13:0] evt_s;
  reg [13:0] evt_prev_q;
  wire [13:0] evt_rise;
  wire rdy_s;
  reg rdy_prev_q;
  reg sts_valid_q;

  pef_sync #(.W(`PEF_STS_W)) u_sync_sts (
    .clk(CLK),
    .rst(RST),
    .d({LNG_XFER_STS, BATTERY_UNDERVOLTAGE_STATUS_N, LINK_MOISTURE_STS,
        SERIAL_SWITCH_OPEN_STS, SWITCH_OFF_STS, CHARGER_PREREQ_STS}),
    .q(sts_s)
  );

  pef_sync #(.W(15)) u_sync_evt (
    .clk(CLK),
    .rst(RST),
    .d({INTERFACE_READY_STS, MOI_DONE_EVT, MOI_VALID_EVT, RES_ABORT_EVT, RES_OPEN_EVT,
        RES_GROUND_EVT, URT_TIMEOUT_EVT, URT_FAIL_EVT, URT_ENTER_EVT, URT_EXIT_EVT,
        DEAD_MASTER_EVT, OTP_DONE_EVT, WDT_TIMEOUT_EVT, WDT_SELF_CLEAR, 1'b0}),
    .q({rdy_s, evt_s})
  );

  // Status history is primed one cycle after reset so that the first sample is no change.
  always @(posedge CLK) begin
    if (RST) begin
      sts_prev_q <= {`PEF_STS_W{1'b0}};
      evt_prev_q <= 14'h0000;
      rdy_prev_q <= 1'b0;
      sts_valid_q <= 1'b0;
    end else begin
      sts_prev_q <= sts_s;
      evt_prev_q <= evt_s;
      rdy_prev_q <= rdy_s;
      sts_valid_q <= 1'b1;
    end
  end

  assign sts_chg = sts_valid_q ? (sts_s ^ sts_prev_q) : {`PEF_STS_W{1'b0}};
  assign evt_rise = evt_s & ~evt_prev_q;

  wire chg_lng = sts_chg[5];
  wire chg_uvlo = sts_chg[4];
  wire chg_moi = sts_chg[3];
  wire chg_swc = sts_chg[2];
  wire chg_off = sts_chg[1];
  wire chg_prq = sts_chg[0];
  wire chg_rdy = sts_valid_q & (rdy_s ^ rdy_prev_q);
  wire ev_moi_done = evt_rise[13];
  wire ev_moi_valid = evt_rise[12];
  wire ev_abr = evt_rise[11];
  wire ev_opn = evt_rise[10];
  wire ev_gnd = evt_rise[9];
  wire ev_tmo = evt_rise[8];
  wire ev_fail = evt_rise[7];
  wire ev_enter = evt_rise[6];
  wire ev_exit = evt_rise[5];
  wire ev_dead = evt_rise[4];
  wire ev_otp = evt_rise[3];
  wire ev_wdt = evt_rise[2];
  wire ev_wself = evt_rise[1];

  // ====================================================================
  // Register access decode
  function sel;
    input [7:0] a;
    input [7:0] r;
    begin
      sel = (a == r);
    end
  endfunction

  wire wr_link = REG_WR & sel(REG_ADDR, `PEF_ADDR_LINK);
  wire wr_uart = REG_WR & sel(REG_ADDR, `PEF_ADDR_UART);
  wire wr_rdy = REG_WR & sel(REG_ADDR, `PEF_ADDR_RDY);
  wire rd_rdy = REG_RD & sel(REG_ADDR, `PEF_ADDR_RDY);

  // Write-one-to-clear masks, restricted to implemented bits.
  wire [7:0] clr_link = wr_link ? (REG_WDATA & `PEF_MASK_LINK) : `PEF_ZERO8; // RULE_17
  wire [7:0] clr_uart = wr_uart ? (REG_WDATA & `PEF_MASK_UART) : `PEF_ZERO8; // RULE_18
  wire [7:0] clr_rdy = wr_rdy ? (REG_WDATA & `PEF_MASK_RDY) : `PEF_ZERO8; // RULE_18

  // ====================================================================
  // Event sets
  reg [7:0] set_link;
  reg [7:0] set_uart;
  reg [7:0] set_rdy;
  always @* begin
    set_link = `PEF_ZERO8;
    set_uart = `PEF_ZERO8;
    set_rdy = `PEF_ZERO8;
    set_link[`PEF_B_LNG_XFER] = chg_lng; // RULE_01
    set_link[`PEF_B_UVLO] = chg_uvlo; // RULE_02
    set_link[`PEF_B_MOI_DONE] = ev_moi_done; // RULE_03
    set_link[`PEF_B_MOI_DET] = chg_moi; // RULE_04
    set_link[`PEF_B_MOI_VALID] = ev_moi_valid; // RULE_05
    set_link[`PEF_B_RES_ABR] = ev_abr; // RULE_06
    set_link[`PEF_B_RES_OPN] = ev_opn; // RULE_06
    set_link[`PEF_B_RES_GND] = ev_gnd; // RULE_06
    set_uart[`PEF_B_URT_TMO] = ev_tmo; // RULE_07
    set_uart[`PEF_B_URT_FAIL] = ev_fail; // RULE_08
    set_uart[`PEF_B_URT_DONE] = ev_enter | ev_exit; // RULE_09
    set_uart[`PEF_B_URT_SWC] = chg_swc; // RULE_10
    set_uart[`PEF_B_DEAD] = ev_dead; // RULE_11
    set_uart[`PEF_B_SWC_OFF] = chg_off; // RULE_12
    set_uart[`PEF_B_CHG_PRQ] = chg_prq; // RULE_13
    set_rdy[`PEF_B_ITF_RDY] = ev_otp | chg_rdy; // RULE_14
    set_rdy[`PEF_B_WDT_CLR] = ev_wdt; // RULE_16
  end

  // ====================================================================
  // Flag registers
  reg [7:0] link_moisture_event_flags_q;
  reg [7:0] uart_mode_event_flags_q;
  reg [7:0] ready_watchdog_flags_q;
  wire [7:0] link_d = ((link_moisture_event_flags_q & ~clr_link) | set_link) & `PEF_MASK_LINK; // RULE_17
  wire [7:0] uart_d = ((uart_mode_event_flags_q & ~clr_uart) | set_uart) & `PEF_MASK_UART; // RULE_18
  // Reading the watchdog bit clears it; a self-clear also drops it. A new timeout wins.
  wire wdt_drop = rd_rdy | ev_wself; // RULE_16
  wire [7:0] rdy_keep = ready_watchdog_flags_q & ~clr_rdy &
                        ~({7'h00, wdt_drop} << `PEF_B_WDT_CLR);
  wire [7:0] rdy_d = (rdy_keep | set_rdy) & `PEF_MASK_RDY; // RULE_18

  always @(posedge CLK) begin
    if (RST) begin
      link_moisture_event_flags_q <= `PEF_RST_LINK;
      uart_mode_event_flags_q <= `PEF_RST_UART;
      ready_watchdog_flags_q <= `PEF_RST_RDY; // RULE_14
    end else begin
      link_moisture_event_flags_q <= link_d;
      uart_mode_event_flags_q <= uart_d;
      ready_watchdog_flags_q <= rdy_d;
    end
  end

  // ====================================================================
  // Read data, registered; the value shown is the one before any clear-on-read.
  reg [7:0] rdata_q;
  always @(posedge CLK) begin
    if (RST) begin
      rdata_q <= `PEF_ZERO8;
    end else if (REG_RD) begin
      if (sel(REG_ADDR, `PEF_ADDR_LINK)) begin
        rdata_q <= link_moisture_event_flags_q;
      end else if (sel(REG_ADDR, `PEF_ADDR_UART)) begin
        rdata_q <= uart_mode_event_flags_q;
      end else if (sel(REG_ADDR, `PEF_ADDR_RDY)) begin
        rdata_q <= ready_watchdog_flags_q; // RULE_15
      end else begin
        rdata_q <= `PEF_ZERO8;
      end
    end
  end
  assign REG_RDATA = rdata_q;

  // The watchdog logic outside sees the bit cleared once the host has read it.
  assign WDT_SERVICED = ~ready_watchdog_flags_q[`PEF_B_WDT_CLR]; // RULE_16

endmodule // pef_event_flags

/* pef_chk.sv */
// Purpose: Assertions on the event flag register port.
// Assumes: Bound to pef_event_flags.
// Notes: Watchdog flag latency is taken as 1 to 4 cycles after a timeout, and 2 to 4 when tracing a set bit to its cause.
`timescale 1ns/100ps
module pef_chk (
  input wire CLK,
  input wire RST,
  input wire [7:0] REG_ADDR,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  input wire WDT_TIMEOUT_EVT,
  input wire WDT_SERVICED
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence quiet_wdt;
    !WDT_TIMEOUT_EVT [*5];
  endsequence
  a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  a_unmapped_zero: assert property (REG_RD && !(REG_ADDR inside {8'h0b, 8'h0c, 8'h0d}) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_resv_uart: assert property (REG_RD && REG_ADDR == 8'h0c |=> !REG_RDATA[2]) else $error("reserved bit set");
  a_resv_ready: assert property (REG_RD && REG_ADDR == 8'h0d |=> (REG_RDATA & 8'h7b) == 8'h00)
    else $error("reserved bits set");
  a_read_clears_wdt: assert property (quiet_wdt ##0 (REG_RD && REG_ADDR == 8'h0d) |=> WDT_SERVICED)
    else $error("read left watchdog bit");
  a_write_clears_wdt: assert property (quiet_wdt ##0 (REG_WR && REG_ADDR == 8'h0d && REG_WDATA[2]) |=> WDT_SERVICED)
    else $error("write left watchdog bit");
  a_timeout_sets_wdt: assert property ($rose(WDT_TIMEOUT_EVT) |-> ##[1:4] !WDT_SERVICED)
    else $error("timeout did not set bit");
  a_wdt_has_cause: assert property ($fell(WDT_SERVICED) |-> $past(WDT_TIMEOUT_EVT, 2) ||
    $past(WDT_TIMEOUT_EVT, 3) || $past(WDT_TIMEOUT_EVT, 4)) else $error("watchdog bit set without timeout");
endmodule // pef_chk
bind pef_event_flags pef_chk u_chk (.CLK, .RST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
  .WDT_TIMEOUT_EVT, .WDT_SERVICED);

/* pef_host.sv */
// Purpose: Host model driving the register port.
// Assumes: One access at a time, launched at a rising edge.
// Notes: Strobes last one cycle; released buses show inverted data.
`timescale 1ns/100ps
module pef_host (
  input wire CLK,
  output logic [7:0] REG_ADDR,
  output logic REG_WR,
  output logic REG_RD,
  output logic [7:0] REG_WDATA
);
  initial begin
    REG_ADDR = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = 8'h00;
  end
  // Reads of the watchdog register clear its timeout bit, which raises WDT_SERVICED.
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    REG_ADDR <= ~a;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    REG_ADDR <= ~a;
    REG_WDATA <= ~d;
  endtask
endmodule // pef_host

/* testbench.sv */
// Purpose: Self-checking bench for the event flag registers.
// Assumes: Sources toggle or pulse one at a time.
// Notes: Each map byte holds register index nibble and bit position.
`timescale 1ns/100ps
module testbench;
  localparam [151:0] SRC_MAP = 152'hd2d7c3c5c5c6c7b0b1b2b3b5d7c0c1c4b4b6b7;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] st = 7'h00;
  logic [12:0] ev = 13'h0000;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, wdt_serviced;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 45859;
  int i;
  logic [7:0] m;
  always #5 clk = ~clk;
  pef_host u_host (.CLK(clk), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata));
  pef_event_flags u_dut (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .LNG_XFER_STS(st[0]), .BATTERY_UNDERVOLTAGE_STATUS_N(st[1]),
    .LINK_MOISTURE_STS(st[2]), .SERIAL_SWITCH_OPEN_STS(st[3]), .SWITCH_OFF_STS(st[4]), .CHARGER_PREREQ_STS(st[5]),
    .INTERFACE_READY_STS(st[6]), .MOI_DONE_EVT(ev[0]), .MOI_VALID_EVT(ev[1]), .RES_ABORT_EVT(ev[2]),
    .RES_OPEN_EVT(ev[3]), .RES_GROUND_EVT(ev[4]), .URT_TIMEOUT_EVT(ev[5]), .URT_FAIL_EVT(ev[6]),
    .URT_ENTER_EVT(ev[7]), .URT_EXIT_EVT(ev[8]), .DEAD_MASTER_EVT(ev[9]), .OTP_DONE_EVT(ev[10]),
    .WDT_TIMEOUT_EVT(ev[11]), .WDT_SELF_CLEAR(ev[12]), .WDT_SERVICED(wdt_serviced));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask
  task automatic fire(input int k);
    @(posedge clk);
    if (k < 7)
      st[k] <= ~st[k];
    else
      ev[k-7] <= 1'b1;
    repeat (2) @(posedge clk);
    ev <= 13'h0000;
    repeat (3) @(posedge clk);
  endtask
  task end_of_test;
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_seen)
      cmp8(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_rd(8'h0b, 8'h00);
    chk_rd(8'h0c, 8'h00);
    chk_rd(8'h0d, 8'h80);
    chk_rd(8'h20, 8'h00);
    u_host.wr(8'h0d, 8'hff);
    u_host.wr(8'h0c, 8'hff);
    chk_rd(8'h0d, 8'h00);
    chk_rd(8'h0c, 8'h00);
    for (int k = 0; k < 40; k++) begin
      i = (k < 19) ? k : {$random(seed)} % 19;
      m = SRC_MAP[8*i +: 8];
      fire(i);
      chk_rd({4'h0, m[7:4]}, 8'h01 << m[2:0]);
      u_host.wr({4'h0, m[7:4]}, (m == 8'hd2) ? 8'h00 : 8'h01 << m[2:0]);
      chk_rd({4'h0, m[7:4]}, 8'h00);
    end
    fire(18);
    fire(19);
    chk_rd(8'h0d, 8'h00);
    repeat (2) @(posedge clk);
    end_of_test;
  end
endmodule // testbench
